// >>> pkg/dtc_pkg.sv
package dtc_pkg;
   localparam int DTC_NUM_TMR = 2;
   localparam logic [7:0] DTC_ADDR_TCS = 8'h88;
   localparam logic [7:0] DTC_ADDR_TMR_MODE = 8'h89;
   localparam logic [7:0] DTC_ADDR_T0_LO = 8'h8a;
   localparam logic [7:0] DTC_ADDR_T1_LO = 8'h8b;
   localparam logic [7:0] DTC_ADDR_T0_HI = 8'h8c;
   localparam logic [7:0] DTC_ADDR_T1_HI = 8'h8d;
   localparam logic [7:0] DTC_ADDR_PORT_CFG = 8'h8e;
   localparam logic [7:0] DTC_TCS_RST = 8'h00;
   localparam logic [7:0] DTC_TMR_MODE_RST = 8'h00;
   localparam logic [7:0] DTC_PORT_CFG_RST = 8'h00;
   localparam logic [7:0] DTC_CNT_RST = 8'h00;
   localparam logic [7:0] DTC_RD_IDLE = 8'h00;
   // control/status bit positions of the first timer; second is +step
   localparam int DTC_TF_BIT0 = 5;
   localparam int DTC_TR_BIT0 = 4;
   localparam int DTC_IE_BIT0 = 1;
   localparam int DTC_IT_BIT0 = 0;
   localparam int DTC_TCS_STEP = 2;
   // mode register: one nibble per timer
   localparam int DTC_MODE_NIB = 4;
   localparam int DTC_GATE_POS = 3;
   localparam int DTC_CT_POS = 2;
   localparam int DTC_MODE_POS = 0;
   localparam int DTC_TOG_EN_BIT0 = 0;
   // one machine cycle in cpu clock periods
   localparam int DTC_MC_CLKS = 6;
   localparam logic [2:0] DTC_MC_LAST = 3'(DTC_MC_CLKS - 1);
   typedef enum logic [1:0] {DTC_M13, DTC_M16, DTC_M8AR, DTC_MSPLIT} dtc_mode_t;
endpackage

// >>> pkg/dtc_cnt_if.sv
`timescale 1ns/1ps
interface dtc_cnt_if;
   dtc_pkg::dtc_mode_t mode;
   logic inc_lo;
   logic inc_hi;
   logic wr_lo;
   logic wr_hi;
   logic [7:0] wdata;
   logic [7:0] lo;
   logic [7:0] hi;
   logic ovf_lo;
   logic ovf_hi;
   modport ctl (
      output mode, inc_lo, inc_hi, wr_lo, wr_hi, wdata,
      input lo, hi, ovf_lo, ovf_hi
   );
   modport cnt (
      input mode, inc_lo, inc_hi, wr_lo, wr_hi, wdata,
      output lo, hi, ovf_lo, ovf_hi
   );
endinterface

// >>> hdl/dtc_cnt.sv
`timescale 1ns/1ps
module dtc_cnt (
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   dtc_cnt_if.cnt io_cnt
);
   logic [7:0] lo_r;
   logic [7:0] lo_nxt;
   logic [7:0] hi_r;
   logic [7:0] hi_nxt;
   logic ovf_lo;
   logic ovf_hi;

   always_comb
   begin
      lo_nxt = lo_r;
      hi_nxt = hi_r;
      ovf_lo = 1'b0;
      ovf_hi = 1'b0;
      unique case (io_cnt.mode)
         dtc_pkg::DTC_M13:
         begin
            // upper three low bits are left alone and carry no meaning
            if (io_cnt.inc_lo)
            begin
               lo_nxt[4:0] = lo_r[4:0] + 5'h01;
               if (lo_r[4:0] == 5'h1f)
               begin
                  hi_nxt = hi_r + 8'h01;
                  ovf_lo = (hi_r == 8'hff);
               end
            end
         end
         dtc_pkg::DTC_M16:
         begin
            if (io_cnt.inc_lo)
            begin
               {hi_nxt, lo_nxt} = {hi_r, lo_r} + 16'h0001;
               ovf_lo = &{hi_r, lo_r};
            end
         end
         dtc_pkg::DTC_M8AR:
         begin
            if (io_cnt.inc_lo)
            begin
               ovf_lo = (lo_r == 8'hff);
               lo_nxt = ovf_lo ? hi_r : lo_r + 8'h01;
            end
         end
         dtc_pkg::DTC_MSPLIT:
         begin
            if (io_cnt.inc_lo)
            begin
               lo_nxt = lo_r + 8'h01;
               ovf_lo = (lo_r == 8'hff);
            end
            if (io_cnt.inc_hi)
            begin
               hi_nxt = hi_r + 8'h01;
               ovf_hi = (hi_r == 8'hff);
            end
         end
      endcase
      // a software write beats a count landing in the same cycle
      if (io_cnt.wr_lo)
         lo_nxt = io_cnt.wdata;
      if (io_cnt.wr_hi)
         hi_nxt = io_cnt.wdata;
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_sys_rst)
      begin
         lo_r <= dtc_pkg::DTC_CNT_RST;
         hi_r <= dtc_pkg::DTC_CNT_RST;
      end
      else
      begin
         lo_r <= lo_nxt;
         hi_r <= hi_nxt;
      end
   end

   assign io_cnt.lo = lo_r;
   assign io_cnt.hi = hi_r;
   assign io_cnt.ovf_lo = ovf_lo;
   assign io_cnt.ovf_hi = ovf_hi;

   property p_reload;
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      (io_cnt.mode == dtc_pkg::DTC_M8AR && io_cnt.inc_lo && lo_r == 8'hff
         && !io_cnt.wr_lo && !io_cnt.wr_hi) |=> lo_r == $past(hi_r)
         && hi_r == $past(hi_r);
   endproperty
   a_reload: assert property (p_reload)
      else $error("auto reload did not copy high byte");

   property p_carry13;
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      (io_cnt.mode == dtc_pkg::DTC_M13 && io_cnt.inc_lo
         && lo_r[4:0] == 5'h1f && !io_cnt.wr_hi && !io_cnt.wr_lo)
         |=> hi_r == $past(hi_r) + 8'h01 && lo_r[4:0] == 5'h00;
   endproperty
   a_carry13: assert property (p_carry13)
      else $error("13-bit carry from prescaler lost");
endmodule

// >>> hdl/dtc_top.sv
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
module dtc_top (
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wr_data,
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   output logic [7:0] o_rd_data,
   input wire logic [1:0] i_count_pin,
   input wire logic [1:0] i_gate_input_pin,
   input wire logic [1:0] i_ovf_ack,
   input wire logic [1:0] i_ext_ack,
   output logic [1:0] o_count_pin_out,
   output logic [1:0] o_count_pin_oe,
   output logic [1:0] o_overflow_flag,
   output logic [1:0] o_ext_irq_flag,
   output logic o_baud_tick
);
   logic [7:0] timer_control_status_r;
   logic [7:0] timer_mode_register_r;
   logic [7:0] pcfg_r;
   logic [7:0] rd_data_r;
   logic [2:0] mc_cnt_r;
   logic mc_tick;
   logic [1:0] gate_s1_r;
   logic [1:0] gate_s2_r;
   logic [1:0] gate_old_r;
   logic [1:0] cnt_s1_r;
   logic [1:0] cnt_s2_r;
   logic [1:0] cnt_smp_r;
   logic [1:0] cnt_fall;
   logic [1:0] gate_ok;
   logic [1:0] src;
   logic [1:0] tf_set;
   logic [1:0] ie_set;
   logic [1:0] tmr_ovf;
   logic [1:0] tog_old_r;
   logic [1:0] pin_out_r;
   logic baud_r;
   logic t0_split;
   logic t1_stop;
   logic t1_run;
   logic wr_timer_control_status;
   dtc_pkg::dtc_mode_t mode0;
   dtc_pkg::dtc_mode_t mode1;

   dtc_cnt_if cif0 ();
   dtc_cnt_if cif1 ();

   function automatic int tf_pos(input int i);
      return dtc_pkg::DTC_TF_BIT0 + dtc_pkg::DTC_TCS_STEP * i;
   endfunction

   function automatic int tr_pos(input int i);
      return dtc_pkg::DTC_TR_BIT0 + dtc_pkg::DTC_TCS_STEP * i;
   endfunction

   function automatic int ie_pos(input int i);
      return dtc_pkg::DTC_IE_BIT0 + dtc_pkg::DTC_TCS_STEP * i;
   endfunction

   function automatic int it_pos(input int i);
      return dtc_pkg::DTC_IT_BIT0 + dtc_pkg::DTC_TCS_STEP * i;
   endfunction

   function automatic dtc_pkg::dtc_mode_t mode_of(input logic [3:0] nib);
      return dtc_pkg::dtc_mode_t'(nib[dtc_pkg::DTC_MODE_POS +: 2]);
   endfunction

   function automatic logic nib_bit(input logic [7:0] r, input int i,
                                    input int pos);
      return r[dtc_pkg::DTC_MODE_NIB * i + pos];
   endfunction

   assign mode0 = mode_of(timer_mode_register_r[3:0]);
   assign mode1 = mode_of(timer_mode_register_r[7:4]);
   assign t0_split = (mode0 == dtc_pkg::DTC_MSPLIT);
   assign t1_stop = (mode1 == dtc_pkg::DTC_MSPLIT);
   assign wr_timer_control_status = i_wr_en && (i_addr == dtc_pkg::DTC_ADDR_TCS);

   // machine cycle divider
   always_ff @(posedge i_clk_sys)
   begin
      if (i_sys_rst || mc_cnt_r == dtc_pkg::DTC_MC_LAST)
         mc_cnt_r <= 3'h0;
      else
         mc_cnt_r <= mc_cnt_r + 3'h1;
   end
   assign mc_tick = (mc_cnt_r == dtc_pkg::DTC_MC_LAST);

   // pins are asynchronous: two flops before anything looks at them
   always_ff @(posedge i_clk_sys)
   begin
      if (i_sys_rst)
      begin
         gate_s1_r <= 2'h3;
         gate_s2_r <= 2'h3;
         gate_old_r <= 2'h3;
         cnt_s1_r <= 2'h0;
         cnt_s2_r <= 2'h0;
      end
      else
      begin
         gate_s1_r <= i_gate_input_pin;
         gate_s2_r <= gate_s1_r;
         gate_old_r <= gate_s2_r;
         cnt_s1_r <= i_count_pin;
         cnt_s2_r <= cnt_s1_r;
      end
   end

   // count pin sampled once per machine cycle
   always_ff @(posedge i_clk_sys)
   begin
      if (i_sys_rst)
         cnt_smp_r <= 2'h0;
      else if (mc_tick)
         cnt_smp_r <= cnt_s2_r;
   end

   always_comb
   begin
      for (int i = 0; i < dtc_pkg::DTC_NUM_TMR; i++)
      begin
         cnt_fall[i] = mc_tick && cnt_smp_r[i] && !cnt_s2_r[i];
         gate_ok[i] = !nib_bit(timer_mode_register_r, i, dtc_pkg::DTC_GATE_POS)
                      || gate_s2_r[i];
         src[i] = nib_bit(timer_mode_register_r, i, dtc_pkg::DTC_CT_POS) ?
                  cnt_fall[i] : mc_tick;
         ie_set[i] = timer_control_status_r[it_pos(i)] ?
                     (gate_old_r[i] && !gate_s2_r[i]) :
                     !gate_s2_r[i];
      end
   end

   // with the first timer split, the second one ignores its run bit
   assign t1_run = t0_split ? 1'b1 : timer_control_status_r[tr_pos(1)];

   always_comb
   begin
      cif0.mode = mode0;
      cif0.inc_lo = timer_control_status_r[tr_pos(0)] && gate_ok[0] && src[0];
      cif0.inc_hi = t0_split && timer_control_status_r[tr_pos(1)] && mc_tick;
      cif0.wr_lo = i_wr_en && (i_addr == dtc_pkg::DTC_ADDR_T0_LO);
      cif0.wr_hi = i_wr_en && (i_addr == dtc_pkg::DTC_ADDR_T0_HI);
      cif0.wdata = i_wr_data;
      cif1.mode = mode1;
      cif1.inc_lo = t1_run && gate_ok[1] && src[1] && !t1_stop;
      cif1.inc_hi = 1'b0;
      cif1.wr_lo = i_wr_en && (i_addr == dtc_pkg::DTC_ADDR_T1_LO);
      cif1.wr_hi = i_wr_en && (i_addr == dtc_pkg::DTC_ADDR_T1_HI);
      cif1.wdata = i_wr_data;
   end

   dtc_cnt u_cnt0 (
      .i_clk_sys(i_clk_sys),
      .i_sys_rst(i_sys_rst),
      .io_cnt(cif0.cnt)
   );

   dtc_cnt u_cnt1 (
      .i_clk_sys(i_clk_sys),
      .i_sys_rst(i_sys_rst),
      .io_cnt(cif1.cnt)
   );

   assign tmr_ovf[0] = cif0.ovf_lo;
   assign tmr_ovf[1] = cif1.ovf_lo;
   assign tf_set[0] = cif0.ovf_lo;
   // split high byte takes over the second flag; second timer's overflow still drives the baud tick and its toggle pin
   assign tf_set[1] = t0_split ? cif0.ovf_hi : cif1.ovf_lo;

   // control/status: writes touch only this register, never the counts
   always_ff @(posedge i_clk_sys)
   begin
      if (i_sys_rst)
         timer_control_status_r <= dtc_pkg::DTC_TCS_RST;
      else
      begin
         if (wr_timer_control_status)
            timer_control_status_r <= i_wr_data;
         for (int i = 0; i < dtc_pkg::DTC_NUM_TMR; i++)
         begin
            // later assignments win: hardware set beats any clear
            if (i_ovf_ack[i])
               timer_control_status_r[tf_pos(i)] <= 1'b0;
            if (tf_set[i])
               timer_control_status_r[tf_pos(i)] <= 1'b1;
            if (i_ext_ack[i])
               timer_control_status_r[ie_pos(i)] <= 1'b0;
            if (ie_set[i])
               timer_control_status_r[ie_pos(i)] <= 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_sys_rst)
         timer_mode_register_r <= dtc_pkg::DTC_TMR_MODE_RST;
      else if (i_wr_en && i_addr == dtc_pkg::DTC_ADDR_TMR_MODE)
         timer_mode_register_r <= i_wr_data;
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_sys_rst)
         pcfg_r <= dtc_pkg::DTC_PORT_CFG_RST;
      else if (i_wr_en && i_addr == dtc_pkg::DTC_ADDR_PORT_CFG)
         pcfg_r <= {6'h00, i_wr_data[dtc_pkg::DTC_TOG_EN_BIT0 +: 2]};
   end

   // read data live for exactly the cycle after the strobe
   always_ff @(posedge i_clk_sys)
   begin
      if (i_sys_rst || !i_rd_en)
         rd_data_r <= dtc_pkg::DTC_RD_IDLE;
      else
      begin
         unique case (i_addr)
            dtc_pkg::DTC_ADDR_TCS: rd_data_r <= timer_control_status_r;
            dtc_pkg::DTC_ADDR_TMR_MODE: rd_data_r <= timer_mode_register_r;
            dtc_pkg::DTC_ADDR_T0_LO: rd_data_r <= cif0.lo;
            dtc_pkg::DTC_ADDR_T1_LO: rd_data_r <= cif1.lo;
            dtc_pkg::DTC_ADDR_T0_HI: rd_data_r <= cif0.hi;
            dtc_pkg::DTC_ADDR_T1_HI: rd_data_r <= cif1.hi;
            dtc_pkg::DTC_ADDR_PORT_CFG: rd_data_r <= pcfg_r;
            default: rd_data_r <= dtc_pkg::DTC_RD_IDLE;
         endcase
      end
   end

   // toggle outputs; pin is still sampled as a count input meanwhile
   always_ff @(posedge i_clk_sys)
   begin
      if (i_sys_rst)
      begin
         tog_old_r <= 2'h0;
         pin_out_r <= 2'h3;
      end
      else
      begin
         for (int i = 0; i < dtc_pkg::DTC_NUM_TMR; i++)
         begin
            tog_old_r[i] <= pcfg_r[dtc_pkg::DTC_TOG_EN_BIT0 + i];
            if (pcfg_r[dtc_pkg::DTC_TOG_EN_BIT0 + i] && !tog_old_r[i])
               pin_out_r[i] <= 1'b1;
            else if (pcfg_r[dtc_pkg::DTC_TOG_EN_BIT0 + i] && tmr_ovf[i])
               pin_out_r[i] <= !pin_out_r[i];
         end
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_sys_rst)
         baud_r <= 1'b0;
      else
         baud_r <= cif1.ovf_lo;
   end

   assign o_rd_data = rd_data_r;
   assign o_count_pin_out = pin_out_r;
   assign o_count_pin_oe = pcfg_r[dtc_pkg::DTC_TOG_EN_BIT0 +: 2];
   assign o_overflow_flag = {timer_control_status_r[tf_pos(1)], timer_control_status_r[tf_pos(0)]};
   assign o_ext_irq_flag = {timer_control_status_r[ie_pos(1)], timer_control_status_r[ie_pos(0)]};
   assign o_baud_tick = baud_r;

   property p_mc_tick;
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      mc_tick |=> !mc_tick [*5] ##1 mc_tick;
   endproperty
   a_mc_tick: assert property (p_mc_tick)
      else $error("machine cycle is not six clocks");

   property p_tf_set;
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      tf_set[0] |=> o_overflow_flag[0];
   endproperty
   a_tf_set: assert property (p_tf_set)
      else $error("overflow did not set first flag");

   property p_tf_ack;
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      (i_ovf_ack[1] && !tf_set[1]) |=> !o_overflow_flag[1];
   endproperty
   a_tf_ack: assert property (p_tf_ack)
      else $error("service did not clear second flag");

   property p_gate_hold;
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      (!(timer_control_status_r[tr_pos(0)] && gate_ok[0]) && !cif0.wr_lo)
         |=> $stable(cif0.lo);
   endproperty
   a_gate_hold: assert property (p_gate_hold)
      else $error("first timer counted while disabled");

   property p_t1_stop;
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      (t1_stop && !cif1.wr_lo && !cif1.wr_hi)
         |=> $stable(cif1.lo) && $stable(cif1.hi);
   endproperty
   a_t1_stop: assert property (p_t1_stop)
      else $error("second timer moved in mode 3");

   property p_split_hi;
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      (t0_split && timer_control_status_r[tr_pos(1)] && mc_tick && !cif0.wr_hi)
         |=> cif0.hi == $past(cif0.hi) + 8'h01;
   endproperty
   a_split_hi: assert property (p_split_hi)
      else $error("split high byte missed a machine cycle");

   property p_tog_first;
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      $rose(o_count_pin_oe[0]) |=> o_count_pin_out[0];
   endproperty
   a_tog_first: assert property (p_tog_first)
      else $error("toggle pin not high after enable");

   property p_tog_flip;
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      (o_count_pin_oe[1] && tog_old_r[1] && tmr_ovf[1])
         |=> o_count_pin_out[1] != $past(o_count_pin_out[1]);
   endproperty
   a_tog_flip: assert property (p_tog_flip)
      else $error("toggle pin did not invert on overflow");

   property p_baud;
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      cif1.ovf_lo |=> o_baud_tick ##1 !o_baud_tick;
   endproperty
   a_baud: assert property (p_baud)
      else $error("baud tick not a single pulse");

   property p_edge;
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      (timer_control_status_r[it_pos(0)] && gate_old_r[0] && !gate_s2_r[0])
         |=> o_ext_irq_flag[0];
   endproperty
   a_edge: assert property (p_edge)
      else $error("falling edge did not set edge flag");
endmodule

// >>> testbench/dtc_pin_model.sv
`timescale 1ns/1ps
module dtc_pin_model (
   input wire logic i_clk_sys,
   input wire logic [1:0] i_pulse,
   input wire logic [1:0] i_gate_lvl,
   output logic [1:0] o_count_pin,
   output logic [1:0] o_gate_pin
);
   logic [4:0] cnt_r [2] = '{5'h00, 5'h00};
   // pins idle high on their pull-up; a pulse is low for 8 clocks,
   // more than one machine cycle, so the sampler cannot skip it
   always_ff @(posedge i_clk_sys)
   begin
      for (int k = 0; k < 2; k++)
      begin
         if (i_pulse[k])
            cnt_r[k] <= 5'h10;
         else if (cnt_r[k] != 5'h00)
            cnt_r[k] <= cnt_r[k] - 5'h01;
      end
   end
   always_comb
   begin
      for (int k = 0; k < 2; k++)
         o_count_pin[k] = !(cnt_r[k] > 5'h08);
      o_gate_pin = i_gate_lvl;
   end
endmodule

// >>> testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic i_clk_sys = 1'b0;
   logic i_sys_rst = 1'b1;
   logic [7:0] i_addr = 8'h00;
   logic [7:0] i_wr_data = 8'h00;
   logic i_wr_en = 1'b0;
   logic i_rd_en = 1'b0;
   logic [1:0] i_ovf_ack = 2'h0;
   logic [1:0] i_ext_ack = 2'h0;
   logic [1:0] pulse = 2'h0;
   logic [1:0] gate_lvl = 2'h3;
   logic [7:0] o_rd_data;
   logic [1:0] pin_m, gate_m, pin_out, pin_oe, ovf, ext, pin_w;
   logic baud;
   int err_count = 0;
   int tests_run = 0;
   int n;
   logic [7:0] d;
   // shared pin: the toggle output wins while it is enabled
   assign pin_w = (pin_oe & pin_out) | (~pin_oe & pin_m);
   initial
   begin
      forever #12.5 i_clk_sys = ~i_clk_sys;
   end
   dtc_top dut (
      .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
      .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
      .o_rd_data(o_rd_data), .i_count_pin(pin_w),
      .i_gate_input_pin(gate_m), .i_ovf_ack(i_ovf_ack),
      .i_ext_ack(i_ext_ack), .o_count_pin_out(pin_out),
      .o_count_pin_oe(pin_oe), .o_overflow_flag(ovf),
      .o_ext_irq_flag(ext), .o_baud_tick(baud)
   );
   dtc_pin_model pins (
      .i_clk_sys(i_clk_sys), .i_pulse(pulse), .i_gate_lvl(gate_lvl),
      .o_count_pin(pin_m), .o_gate_pin(gate_m)
   );
   task automatic give_verdict;
      $display("errors %0d checks %0d", err_count, tests_run);
      if (err_count == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         err_count++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge i_clk_sys);
      i_addr <= a;
      i_wr_data <= v;
      i_wr_en <= 1'b1;
      @(posedge i_clk_sys);
      i_wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge i_clk_sys);
      i_addr <= a;
      i_rd_en <= 1'b1;
      @(posedge i_clk_sys);
      i_rd_en <= 1'b0;
      @(negedge i_clk_sys);
      d = o_rd_data;
   endtask
   task automatic fail_wait;
      err_count++;
      $display("ERROR %0t wait ran out", $time);
      give_verdict();
   endtask
   task automatic wait_ovf(input int k);
      n = 0;
      while (ovf[k] !== 1'b1)
      begin
         @(negedge i_clk_sys);
         n++;
         if (n > 3000)
            fail_wait();
      end
   endtask
   // clocks between two baud pulses; a stuck-high pulse gives 1
   task automatic baud_gap;
      n = 0;
      while (baud !== 1'b1)
      begin
         @(negedge i_clk_sys);
         n++;
         if (n > 100)
            fail_wait();
      end
      n = 0;
      do
      begin
         @(negedge i_clk_sys);
         n++;
      end while (baud !== 1'b1 && n < 100);
   endtask
   task automatic ack(input logic ovf_side, input logic [1:0] m);
      @(posedge i_clk_sys);
      if (ovf_side)
         i_ovf_ack <= m;
      else
         i_ext_ack <= m;
      @(posedge i_clk_sys);
      i_ovf_ack <= 2'h0;
      i_ext_ack <= 2'h0;
      @(negedge i_clk_sys);
   endtask
   initial
   begin
      repeat (20) @(posedge i_clk_sys);
      i_sys_rst <= 1'b0;
      for (int a = 8'h88; a <= 8'h90; a++)
      begin
         rd(8'(a));
         chk(d, 8'h00);
      end
      chk({6'h00, pin_out}, 8'h03);
      // first timer, reload mode, gated, toggling
      wr(8'h8a, 8'hfe);
      wr(8'h8c, 8'hf0);
      gate_lvl <= 2'h2;
      wr(8'h89, 8'h0a);
      wr(8'h8e, 8'h01);
      // enable lands at the write edge: look once it has settled
      @(negedge i_clk_sys);
      chk({6'h00, pin_oe[0], pin_w[0]}, 8'h03);
      wr(8'h88, 8'h10);
      repeat (20) @(posedge i_clk_sys);
      rd(8'h8a);
      chk(d, 8'hfe);
      gate_lvl <= 2'h3;
      wait_ovf(0);
      rd(8'h8a);
      chk(d, 8'hf0);
      rd(8'h8c);
      chk(d, 8'hf0);
      chk({7'h00, pin_w[0]}, 8'h00);
      ack(1'b1, 2'h1);
      chk({6'h00, ovf}, 8'h00);
      wr(8'h88, 8'h00);
      wr(8'h8e, 8'h00);
      // second timer reloads 0xff: one overflow per machine cycle
      wr(8'h8b, 8'hff);
      wr(8'h8d, 8'hff);
      wr(8'h89, 8'h20);
      wr(8'h8e, 8'h02);
      wr(8'h88, 8'h40);
      baud_gap();
      chk(8'(n), 8'h06);
      wr(8'h88, 8'h00);
      wr(8'h8e, 8'h00);
      // second timer, 16-bit
      wr(8'h8b, 8'hfe);
      wr(8'h89, 8'h10);
      wr(8'h88, 8'h40);
      wait_ovf(1);
      rd(8'h8b);
      chk(d, 8'h00);
      rd(8'h8d);
      chk(d, 8'h00);
      wr(8'h88, 8'h00);
      // first timer, 13-bit: low byte carries out of bit 4
      wr(8'h8a, 8'h1e);
      wr(8'h8c, 8'hff);
      wr(8'h89, 8'h00);
      wr(8'h88, 8'h10);
      wait_ovf(0);
      rd(8'h8c);
      chk(d, 8'h00);
      rd(8'h8a);
      chk({3'h0, d[4:0]}, 8'h00);
      wr(8'h88, 8'h00);
      // first timer counts falling pin edges
      wr(8'h8a, 8'h00);
      wr(8'h89, 8'h06);
      wr(8'h88, 8'h10);
      repeat (3)
      begin
         @(posedge i_clk_sys);
         pulse <= 2'h1;
         @(posedge i_clk_sys);
         pulse <= 2'h0;
         repeat (30) @(posedge i_clk_sys);
      end
      rd(8'h8a);
      chk(d, 8'h03);
      // split mode with the second timer parked in mode 3
      wr(8'h88, 8'h00);
      wr(8'h8a, 8'h00);
      wr(8'h8b, 8'h55);
      wr(8'h8c, 8'hfe);
      wr(8'h89, 8'h33);
      // both run bits: low byte and high byte tick side by side
      wr(8'h88, 8'h50);
      wait_ovf(1);
      rd(8'h8a);
      chk(d, 8'h02);
      rd(8'h8b);
      chk(d, 8'h55);
      wr(8'h8b, 8'hff);
      // high byte was left at zero by the 16-bit wrap; reload 0xff
      wr(8'h8d, 8'hff);
      wr(8'h89, 8'h23);
      baud_gap();
      chk(8'(n), 8'h06);
      wr(8'h88, 8'h00);
      wr(8'h89, 8'h00);
      // external irq a on falling edge, b on low level
      wr(8'h88, 8'h01);
      gate_lvl <= 2'h2;
      repeat (6) @(negedge i_clk_sys);
      chk({6'h00, ext}, 8'h01);
      @(posedge i_clk_sys);
      gate_lvl <= 2'h3;
      ack(1'b0, 2'h1);
      chk({6'h00, ext}, 8'h00);
      gate_lvl <= 2'h1;
      repeat (6) @(negedge i_clk_sys);
      ack(1'b0, 2'h2);
      chk({6'h00, ext}, 8'h02);
      @(posedge i_clk_sys);
      gate_lvl <= 2'h3;
      repeat (4) @(posedge i_clk_sys);
      ack(1'b0, 2'h2);
      chk({6'h00, ext}, 8'h00);
      give_verdict();
   end
endmodule
